/* include/ais_pkg.sv */
package ais_pkg;
    // register word offsets on the plain register port
    localparam logic [3:0] AIS_OFS_CH0_SEL_1 = 4'h0;
    localparam logic [3:0] AIS_OFS_SCAN_HI_1 = 4'h1;
    localparam logic [3:0] AIS_OFS_SCAN_LO_1 = 4'h2;
    localparam logic [3:0] AIS_OFS_PIN_DIGITAL_MODE_BITS_HI_1 = 4'h3;
    localparam logic [3:0] AIS_OFS_PIN_DIGITAL_MODE_BITS_LO_1 = 4'h4;
    localparam logic [3:0] AIS_OFS_CTRL_1 = 4'h5;
    localparam logic [3:0] AIS_OFS_CH0_SEL_2 = 4'h8;
    localparam logic [3:0] AIS_OFS_SCAN_HI_2 = 4'h9;
    localparam logic [3:0] AIS_OFS_SCAN_LO_2 = 4'hA;
    localparam logic [3:0] AIS_OFS_PIN_DIGITAL_MODE_BITS_LO_2 = 4'hC;
    localparam logic [3:0] AIS_OFS_CTRL_2 = 4'hD;
    localparam logic [3:0] AIS_OFS_STATUS = 4'hF;
    // channel 0 select field layout
    localparam int AIS_POS_A_LSB = 0;
    localparam int AIS_NEG_A_BIT = 7;
    localparam int AIS_POS_B_LSB = 8;
    localparam int AIS_NEG_B_BIT = 15;
    localparam logic [15:0] AIS_CH0_SEL_MASK = 16'h9F9F;
    // control register layout
    localparam int AIS_CTRL_ALT_BIT = 0;
    localparam int AIS_CTRL_SCAN_BIT = 10;
    localparam int AIS_CTRL_DIS_BIT = 15;
    localparam logic [15:0] AIS_CTRL_MASK = 16'h8401;
    localparam logic [15:0] AIS_RESET_VALUE = 16'h0000;
    // negative input source codes
    localparam logic AIS_NEG_REF = 1'b0;
    localparam logic AIS_NEG_AN1 = 1'b1;
endpackage

/* design/ais_conv_sel.sv */
`timescale 1ns/1ps
// one converter's channel 0 sequencing: sample a/b alternation and scan walk
module ais_conv_sel
    import ais_pkg::*;
#(
    parameter int NUM_IN = 32,
    parameter int SEL_W = 5
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic sample_i,
    input wire logic [15:0] ch0_sel_i,
    input wire logic [31:0] scan_i,
    input wire logic scan_en_i,
    input wire logic alt_en_i,
    output logic [SEL_W-1:0] pos_o,
    output logic neg_o,
    output logic use_b_o
);
    logic [SEL_W-1:0] scan_ptr;
    logic [SEL_W-1:0] next_scan_ptr;
    logic [SEL_W-1:0] pos_a;
    logic [SEL_W-1:0] pos_b;
    logic found_hi;
    logic found_lo;
    logic [SEL_W-1:0] hi_idx;
    logic [SEL_W-1:0] lo_idx;

    assign pos_a = ch0_sel_i[AIS_POS_A_LSB +: SEL_W];
    assign pos_b = ch0_sel_i[AIS_POS_B_LSB +: SEL_W];

    // next selected input above the pointer, else lowest selected
    always_comb begin
        found_hi = 1'b0;
        found_lo = 1'b0;
        hi_idx = '0;
        lo_idx = '0;
        for (int i = NUM_IN - 1; i >= 0; i--) begin
            if (scan_i[i]) begin
                lo_idx = SEL_W'(i);
                found_lo = 1'b1;
                if (SEL_W'(i) > scan_ptr) begin
                    hi_idx = SEL_W'(i);
                    found_hi = 1'b1;
                end
            end
        end
        if (found_hi) begin
            next_scan_ptr = hi_idx;
        end else if (found_lo) begin
            next_scan_ptr = lo_idx;
        end else begin
            next_scan_ptr = scan_ptr;
        end
    end

    // the pointer holds the last scanned input; the first step after enable takes the lowest
    logic scan_started;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scan_ptr <= '0;
            scan_started <= 1'b0;
            use_b_o <= 1'b0;
        end else if (ce_i) begin
            // clearing alternation returns to sample a at once, not at the next sample
            if (!alt_en_i) begin
                use_b_o <= 1'b0;
            end else if (sample_i) begin
                use_b_o <= !use_b_o;
            end
            // only step when sample a comes next, so b samples do not skip inputs
            if (!scan_en_i) begin
                scan_started <= 1'b0;
            end else if (sample_i && (!alt_en_i || use_b_o)) begin
                scan_started <= 1'b1;
                if (!scan_started && found_lo) begin
                    scan_ptr <= lo_idx;
                end else begin
                    scan_ptr <= next_scan_ptr;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pos_o <= '0;
            neg_o <= AIS_NEG_REF;
        end else if (ce_i) begin
            if (use_b_o) begin
                pos_o <= pos_b;
                neg_o <= ch0_sel_i[AIS_NEG_B_BIT];
            end else begin
                pos_o <= (scan_en_i && scan_started) ? scan_ptr : pos_a;
                neg_o <= ch0_sel_i[AIS_NEG_A_BIT];
            end
        end
    end
endmodule

/* design/ais_pin_mode.sv */
`timescale 1ns/1ps
// per-pin analog/digital resolution for all 32 pins, the shared pins 0-15 and the first converter's own pins
module ais_pin_mode
    import ais_pkg::*;
#(
    parameter int NUM_PINS = 32
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [31:0] pcfg1_i,
    input wire logic [15:0] pcfg2_i,
    input wire logic dis1_i,
    input wire logic dis2_i,
    output logic [NUM_PINS-1:0] digital_o
);
    // a net, so every pin slice may be driven from its own generate branch
    wire logic [NUM_PINS-1:0] next_digital;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            logic dig1;
            logic dig2;
            // a disabled converter forces digital; a shared pin is digital only when both converters claim it
            assign dig1 = dis1_i || pcfg1_i[g];
            if (g < 16) begin : g_shared
                assign dig2 = dis2_i || pcfg2_i[g];
            end else begin : g_first
                assign dig2 = 1'b1;
            end
            assign next_digital[g] = dig1 && dig2;
        end
    endgenerate

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            digital_o <= '0;
        end else if (ce_i) begin
            digital_o <= next_digital;
        end
    end
endmodule

/* design/ais_top.sv */
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - sample a field picks positive input N
// - sample b field, same mapping, bits 12-8
// - neg bit: 1 input 1, 0 low reference
// - sample b neg bit 15, same encoding
// - second converter reaches inputs 0-15 only
// - scan bit x includes input x
// - scan bits writable; missing input converts reference
// - pin_digital_mode_bits set: digital, port read on, mux grounded
// - pin_digital_mode_bits clear: analog, port read off
// - all pin_digital_mode_bits bits rw; missing pins ignored
// - high pin_digital_mode_bits register only for first converter
// - both low pin_digital_mode_bits registers affect shared pins
// - disabled converter: pins digital, pin_digital_mode_bits ignored; a shared pin still follows the other converter's claim
// - unimplemented read zero; reset clears all
// - scan enable steps sample a positive input
// - alternate enable swaps sample a and b
module ais_top
    import ais_pkg::*;
#(
    parameter int NUM_PINS = 32
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic sample1_i,
    input wire logic sample2_i,
    output logic [15:0] rdata_o,
    output logic [4:0] conv1_pos_o,
    output logic conv1_pos_ref_o,
    output logic conv1_neg_o,
    output logic [4:0] conv2_pos_o,
    output logic conv2_pos_ref_o,
    output logic conv2_neg_o,
    output logic [31:0] pin_digital_o,
    output logic [31:0] port_read_en_o,
    output logic [31:0] mux_ground_o
);
    logic [15:0] ch0_sel1;
    logic [15:0] ch0_sel2;
    logic [31:0] scan1;
    logic [31:0] scan2;
    logic [31:0] pcfg1;
    logic [15:0] pcfg2;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [4:0] pos1;
    logic [3:0] pos2;
    logic neg1;
    logic neg2;
    logic use_b1;
    logic use_b2;
    logic [31:0] dig;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        return wr_i && (a == ofs);
    endfunction

    // register writes; unimplemented bits never store
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ch0_sel1 <= AIS_RESET_VALUE;
            ch0_sel2 <= AIS_RESET_VALUE;
            scan1 <= {AIS_RESET_VALUE, AIS_RESET_VALUE};
            scan2 <= {AIS_RESET_VALUE, AIS_RESET_VALUE};
            pcfg1 <= {AIS_RESET_VALUE, AIS_RESET_VALUE};
            pcfg2 <= AIS_RESET_VALUE;
            ctrl1 <= AIS_RESET_VALUE;
            ctrl2 <= AIS_RESET_VALUE;
        end else if (ce_i) begin
            if (hit(addr_i, AIS_OFS_CH0_SEL_1)) begin
                ch0_sel1 <= wdata_i & AIS_CH0_SEL_MASK;
            end
            if (hit(addr_i, AIS_OFS_CH0_SEL_2)) begin
                ch0_sel2 <= wdata_i & AIS_CH0_SEL_MASK;
            end
            if (hit(addr_i, AIS_OFS_SCAN_HI_1)) begin
                scan1[31:16] <= wdata_i;
            end
            if (hit(addr_i, AIS_OFS_SCAN_LO_1)) begin
                scan1[15:0] <= wdata_i;
            end
            if (hit(addr_i, AIS_OFS_SCAN_HI_2)) begin
                scan2[31:16] <= wdata_i;
            end
            if (hit(addr_i, AIS_OFS_SCAN_LO_2)) begin
                scan2[15:0] <= wdata_i;
            end
            if (hit(addr_i, AIS_OFS_PIN_DIGITAL_MODE_BITS_HI_1)) begin
                pcfg1[31:16] <= wdata_i;
            end
            if (hit(addr_i, AIS_OFS_PIN_DIGITAL_MODE_BITS_LO_1)) begin
                pcfg1[15:0] <= wdata_i;
            end
            if (hit(addr_i, AIS_OFS_PIN_DIGITAL_MODE_BITS_LO_2)) begin
                pcfg2 <= wdata_i;
            end
            if (hit(addr_i, AIS_OFS_CTRL_1)) begin
                ctrl1 <= wdata_i & AIS_CTRL_MASK;
            end
            if (hit(addr_i, AIS_OFS_CTRL_2)) begin
                ctrl2 <= wdata_i & AIS_CTRL_MASK;
            end
        end
    end

    // read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 16'h0000;
        end else if (ce_i) begin
            if (rd_i) begin
                unique case (addr_i)
                    AIS_OFS_CH0_SEL_1: rdata_o <= ch0_sel1;
                    AIS_OFS_SCAN_HI_1: rdata_o <= scan1[31:16];
                    AIS_OFS_SCAN_LO_1: rdata_o <= scan1[15:0];
                    AIS_OFS_PIN_DIGITAL_MODE_BITS_HI_1: rdata_o <= pcfg1[31:16];
                    AIS_OFS_PIN_DIGITAL_MODE_BITS_LO_1: rdata_o <= pcfg1[15:0];
                    AIS_OFS_CTRL_1: rdata_o <= ctrl1;
                    AIS_OFS_CH0_SEL_2: rdata_o <= ch0_sel2;
                    AIS_OFS_SCAN_HI_2: rdata_o <= scan2[31:16];
                    AIS_OFS_SCAN_LO_2: rdata_o <= scan2[15:0];
                    AIS_OFS_PIN_DIGITAL_MODE_BITS_LO_2: rdata_o <= pcfg2;
                    AIS_OFS_CTRL_2: rdata_o <= ctrl2;
                    AIS_OFS_STATUS: rdata_o <= {14'h0000, use_b2, use_b1};
                    default: rdata_o <= 16'h0000;
                endcase
            end else begin
                rdata_o <= 16'h0000;
            end
        end
    end

    ais_conv_sel #(
        .NUM_IN(32),
        .SEL_W(5)
    ) u_sel1 (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .sample_i(sample1_i),
        .ch0_sel_i(ch0_sel1),
        .scan_i(scan1),
        .scan_en_i(ctrl1[AIS_CTRL_SCAN_BIT]),
        .alt_en_i(ctrl1[AIS_CTRL_ALT_BIT]),
        .pos_o(pos1),
        .neg_o(neg1),
        .use_b_o(use_b1)
    );

    // second converter only sees four select bits and scan bits 0-15
    ais_conv_sel #(
        .NUM_IN(16),
        .SEL_W(4)
    ) u_sel2 (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .sample_i(sample2_i),
        .ch0_sel_i({ch0_sel2[15], 3'b000, ch0_sel2[11:8], ch0_sel2[7], 3'b000, ch0_sel2[3:0]}),
        .scan_i({16'h0000, scan2[15:0]}),
        .scan_en_i(ctrl2[AIS_CTRL_SCAN_BIT]),
        .alt_en_i(ctrl2[AIS_CTRL_ALT_BIT]),
        .pos_o(pos2),
        .neg_o(neg2),
        .use_b_o(use_b2)
    );

    ais_pin_mode #(
        .NUM_PINS(32)
    ) u_pins (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .pcfg1_i(pcfg1),
        .pcfg2_i(pcfg2),
        .dis1_i(ctrl1[AIS_CTRL_DIS_BIT]),
        .dis2_i(ctrl2[AIS_CTRL_DIS_BIT]),
        .digital_o(dig)
    );

    // a select beyond the fitted pins converts the low reference instead
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv1_pos_o <= 5'h00;
            conv1_pos_ref_o <= 1'b0;
            conv1_neg_o <= AIS_NEG_REF;
            conv2_pos_o <= 5'h00;
            conv2_pos_ref_o <= 1'b0;
            conv2_neg_o <= AIS_NEG_REF;
        end else if (ce_i) begin
            conv1_pos_o <= pos1;
            conv1_pos_ref_o <= (32'(pos1) >= NUM_PINS);
            conv1_neg_o <= neg1;
            conv2_pos_o <= {1'b0, pos2};
            conv2_pos_ref_o <= (32'(pos2) >= NUM_PINS);
            conv2_neg_o <= neg2;
        end
    end

    // pins at and above NUM_PINS do not exist: held analog-idle, bits ignored
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_digital_o <= 32'h0000_0000;
            port_read_en_o <= 32'h0000_0000;
            mux_ground_o <= 32'h0000_0000;
        end else if (ce_i) begin
            for (int i = 0; i < 32; i++) begin
                pin_digital_o[i] <= (i < NUM_PINS) && dig[i];
                port_read_en_o[i] <= (i < NUM_PINS) && dig[i];
                mux_ground_o[i] <= (i < NUM_PINS) && dig[i];
            end
        end
    end
endmodule

/* bench/ais_pin_model.sv */
`timescale 1ns/1ps
// what channel 0 positive input of the first converter really sees
module ais_pin_model (
    input wire logic [31:0] mux_ground_i,
    input wire logic [4:0] pos_i,
    input wire logic pos_ref_i,
    output logic [7:0] level_o
);
    // a pin shows its number plus one, so a wrong route cannot pass for ground (00) or reference (ff)
    always_comb begin
        if (pos_ref_i) begin
            level_o = 8'hFF;
        end else if (mux_ground_i[pos_i]) begin
            level_o = 8'h00;
        end else begin
            level_o = {3'b000, pos_i} + 8'h01;
        end
    end
endmodule

/* bench/ais_top_checker.sv */
`timescale 1ns/1ps
module ais_top_checker
    import ais_pkg::*;
#(
    parameter int NUM_PINS = 32
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic sample1_i,
    input wire logic [15:0] rdata_o,
    input wire logic [4:0] conv1_pos_o,
    input wire logic conv1_pos_ref_o,
    input wire logic [4:0] conv2_pos_o,
    input wire logic [31:0] pin_digital_o,
    input wire logic [31:0] port_read_en_o,
    input wire logic [31:0] mux_ground_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_RDATA_IDLE: assert property ($past(ce_i) && !$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero when idle");
    AST_CH0_GAPS: assert property ($past(ce_i && rd_i && addr_i == 4'h0) |-> (rdata_o & 16'h6060) == 16'h0000)
        else $error("unused select bits read nonzero");
    AST_CH0_WR_RD: assert property ((ce_i && wr_i && addr_i == 4'h0) ##1 (ce_i && rd_i && addr_i == 4'h0)
        |=> rdata_o == ($past(wdata_i, 2) & 16'h9F9F)) else $error("select readback wrong");
    AST_SCAN_WR_RD: assert property ((ce_i && wr_i && addr_i == 4'h1) ##1 (ce_i && rd_i && addr_i == 4'h1)
        |=> rdata_o == $past(wdata_i, 2)) else $error("scan readback wrong");
    AST_PORT_READ: assert property (port_read_en_o == pin_digital_o)
        else $error("port read enable differs from pin mode");
    AST_MUX_GND: assert property (mux_ground_o == pin_digital_o)
        else $error("mux ground differs from pin mode");
    AST_CONV2_RANGE: assert property (conv2_pos_o[4] == 1'b0)
        else $error("second converter above input 15");
    AST_POS_REF: assert property (conv1_pos_ref_o == (int'(conv1_pos_o) >= NUM_PINS))
        else $error("reference flag wrong for input");
    AST_PIN_HOLD: assert property ((ce_i && !wr_i) [*5] |-> $stable(pin_digital_o))
        else $error("pin mode moved without a write");
    AST_CONV_HOLD: assert property ((ce_i && !wr_i && !sample1_i) [*5] |-> $stable(conv1_pos_o))
        else $error("input moved without sample or write");
    COV_WR_RD: cover property ((wr_i && addr_i == 4'h0) ##1 (rd_i && addr_i == 4'h0));
    COV_SAMPLE: cover property (sample1_i ##3 $changed(conv1_pos_o));
    COV_PINS: cover property (pin_digital_o != 32'h0000_0000);
endmodule

bind ais_top ais_top_checker #(.NUM_PINS(NUM_PINS)) ais_top_checker_inst (.clk_i, .reset_n_i, .ce_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .sample1_i, .rdata_o, .conv1_pos_o, .conv1_pos_ref_o, .conv2_pos_o, .pin_digital_o,
    .port_read_en_o, .mux_ground_o);

/* bench/ais_top_tb.sv */
`timescale 1ns/1ps
module ais_top_tb
    import ais_pkg::*;
;
    // fewer fitted pins than select codes, so missing inputs are reachable
    localparam int NP = 20;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sample1_i = 1'b0;
    logic sample2_i = 1'b0;
    logic ce_i = 1'b1;
    logic [15:0] rdata_o;
    logic [4:0] conv1_pos_o, conv2_pos_o;
    logic conv1_pos_ref_o, conv1_neg_o, conv2_pos_ref_o, conv2_neg_o;
    logic [31:0] pin_digital_o, port_read_en_o, mux_ground_o;
    logic [7:0] level;
    int err_count = 0;
    int n_compared = 0;

    ais_top #(.NUM_PINS(NP)) ais_top_inst (.clk_i, .reset_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .sample1_i, .sample2_i, .rdata_o, .conv1_pos_o, .conv1_pos_ref_o, .conv1_neg_o, .conv2_pos_o,
        .conv2_pos_ref_o, .conv2_neg_o, .pin_digital_o, .port_read_en_o, .mux_ground_o);
    ais_pin_model ais_pin_model_inst (.mux_ground_i(mux_ground_o), .pos_i(conv1_pos_o),
        .pos_ref_i(conv1_pos_ref_o), .level_o(level));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, a, d);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        op(1'b0, 1'b1, a, 16'h0000);
        op(1'b0, 1'b0, a, 16'h0000);
        #1;
        chk(32'(rdata_o), 32'(exp));
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic pulse;
        @(posedge clk_i);
        sample1_i <= 1'b1;
        sample2_i <= 1'b1;
        @(posedge clk_i);
        sample1_i <= 1'b0;
        sample2_i <= 1'b0;
        settle();
    endtask

    task automatic t_reset;
        for (int i = 0; i < 16; i++) rd(4'(i), 16'h0000);
        chk(32'(conv1_pos_o), 32'h0000_0000);
        chk(pin_digital_o, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_regs;
        logic [3:0] ad [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hB};
        logic [15:0] ex [12] = '{16'h9F9F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h8401, 16'h9F9F,
            16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h8401, 16'h0000};
        for (int i = 0; i < 12; i++) op(1'b1, 1'b0, ad[i], 16'hFFFF);
        for (int i = 0; i < 12; i++) rd(ad[i], ex[i]);
        for (int i = 0; i < 12; i++) op(1'b1, 1'b0, ad[i], 16'h0000);
        op(1'b0, 1'b0, 4'h0, 16'h0000);
        $display("test registers done");
    endtask

    task automatic t_fixed;
        logic [4:0] n [4] = '{5'd0, 5'd5, 5'd19, 5'd31};
        logic [15:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {8'h00, n[i][0], 2'b00, n[i]};
            op(1'b1, 1'b0, 4'h8, v);
            op(1'b1, 1'b0, 4'h0, v);
            rd(4'h0, v);
            settle();
            chk(32'(conv1_pos_o), 32'(n[i]));
            chk(32'(conv1_neg_o), 32'(n[i][0]));
            chk(32'(conv1_pos_ref_o), 32'(n[i] >= NP));
            chk(32'(level), (n[i] >= NP) ? 32'h0000_00FF : 32'(n[i]) + 32'h1);
            chk(32'(conv2_pos_o), 32'(n[i][3:0]));
            chk(32'(conv2_neg_o), 32'(n[i][0]));
            chk(32'(conv2_pos_ref_o), 32'(32'(n[i][3:0]) >= NP));
        end
        $display("test fixed select done");
    endtask

    // the second converter's bit 12 is set but must not reach its select
    task automatic t_alt;
        wr(4'h0, 16'h8703);
        wr(4'h8, 16'h9703);
        wr(4'h5, 16'h0001);
        wr(4'hD, 16'h0001);
        pulse();
        chk(32'({conv1_neg_o, conv1_pos_o}), 32'h0000_0027);
        chk(32'({conv2_neg_o, conv2_pos_o}), 32'h0000_0027);
        pulse();
        chk(32'({conv1_neg_o, conv1_pos_o}), 32'h0000_0003);
        chk(32'({conv2_neg_o, conv2_pos_o}), 32'h0000_0003);
        pulse();
        wr(4'h5, 16'h0000);
        settle();
        chk(32'({conv1_neg_o, conv1_pos_o}), 32'h0000_0003);
        wr(4'hD, 16'h0000);
        $display("test alternate done");
    endtask

    // the second converter ignores its high scan bits
    task automatic t_scan;
        logic [4:0] ex [4] = '{5'd2, 5'd9, 5'd22, 5'd2};
        logic [4:0] ex2 [4] = '{5'd2, 5'd9, 5'd2, 5'd9};
        wr(4'h2, 16'h0204);
        op(1'b1, 1'b0, 4'h1, 16'h0040);
        rd(4'h1, 16'h0040);
        wr(4'h5, 16'h0400);
        wr(4'hA, 16'h0204);
        wr(4'h9, 16'h0040);
        wr(4'hD, 16'h0400);
        for (int i = 0; i < 4; i++) begin
            pulse();
            chk(32'(conv1_pos_o), 32'(ex[i]));
            chk(32'(conv1_pos_ref_o), 32'(ex[i] >= NP));
            chk(32'(conv2_pos_o), 32'(ex2[i]));
        end
        wr(4'h5, 16'h0000);
        wr(4'h5, 16'h0400);
        pulse();
        chk(32'(conv1_pos_o), 32'h0000_0002);
        wr(4'h5, 16'h0000);
        wr(4'hD, 16'h0000);
        $display("test scan done");
    endtask

    // pins at and above NP are not fitted, so their mode is masked off
    task automatic t_pins;
        wr(4'h4, 16'h00F0);
        wr(4'hC, 16'h0030);
        wr(4'h3, 16'h0003);
        wr(4'h0, 16'h0006);
        settle();
        chk(pin_digital_o & 32'h000F_FFFF, 32'h0003_0030);
        chk(32'(level), 32'h0000_0007);
        wr(4'h0, 16'h0005);
        settle();
        chk(32'(level), 32'h0000_0000);
        wr(4'hD, 16'h8000);
        settle();
        chk(pin_digital_o & 32'h000F_FFFF, 32'h0003_00F0);
        wr(4'h5, 16'h8000);
        settle();
        chk(pin_digital_o & 32'h000F_FFFF, 32'h000F_FFFF);
        $display("test pins done");
    endtask

    // a low clock enable must swallow a write, so the first select value stays in the register and on conv1_pos_o
    task automatic t_hold;
        wr(4'h0, 16'h0011);
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(4'h0, 16'h0002);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd(4'h0, 16'h0011);
        settle();
        chk(32'(conv1_pos_o), 32'h0000_0011);
        $display("test clock enable done");
    endtask

    // reset in mid-run, after every register has been touched
    task automatic t_midreset;
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
    endtask

    initial begin
        #100000;
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_regs();
        t_fixed();
        t_alt();
        t_scan();
        t_pins();
        t_hold();
        t_midreset();
        give_verdict();
    end
endmodule
